// [lsm_pkg.sv]
// Package for the low supply monitor: offsets, fields, resets, timing, types
package lsm_pkg;

  // ==========================================================================
  // Register offsets (byte addresses, one aligned word each)
  localparam logic [3:0] LSM_CTRL_OFS = 4'h0;
  localparam logic [3:0] LSM_STAT_OFS = 4'h4;
  localparam logic [3:0] LSM_MASK_OFS = 4'h8;

  // ==========================================================================
  // Control register field positions
  localparam int LSM_THR_LSB = 0;
  localparam int LSM_THR_MSB = 2;
  localparam int LSM_EN_BIT = 4;
  localparam int LSM_FLAG_BIT = 5;

  // Status and mask field positions
  localparam int LSM_IRQ_BIT = 0;
  localparam int LSM_WAKE_BIT = 1;

  // ==========================================================================
  // Reset values
  localparam logic [2:0] LSM_THR_RST = 3'h0;
  localparam logic LSM_EN_RST = 1'b0;
  localparam logic [1:0] LSM_STAT_RST = 2'h0;
  localparam logic [1:0] LSM_MASK_RST = 2'h0;

  // ==========================================================================
  // Timing: clock, interrupt delay and settle delay
  localparam int LSM_CLK_NS = 100;
  localparam int LSM_IRQ_DELAY_NS = 1000;
  localparam int LSM_IRQ_DELAY_CYC = (LSM_IRQ_DELAY_NS + LSM_CLK_NS - 1) / LSM_CLK_NS;
  localparam int LSM_SETTLE_NS = 2000;
  localparam int LSM_SETTLE_CYC = (LSM_SETTLE_NS + LSM_CLK_NS - 1) / LSM_CLK_NS;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic enable;
    logic [2:0] threshold;
  } lsm_ctrl_s;

  typedef enum logic [1:0] {
    LSM_IDLE,
    LSM_WAIT,
    LSM_FIRED
  } lsm_state_e;

endpackage : lsm_pkg

// [lsm_delay.sv]
// Delay counter that raises a pulse after a flag has stood high a fixed time
`timescale 1ns/10ps
module lsm_delay
  import lsm_pkg::*;
#(
  parameter int DELAY_CYC = LSM_IRQ_DELAY_CYC
)
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic level,
  output logic fire,
  output logic busy
);

  localparam int CW = $clog2(DELAY_CYC + 1);

  lsm_state_e state;
  lsm_state_e next_state;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic next_fire;

  // Next state: count while the level stands, fire once on expiry
  always_comb
  begin
    next_state = state;
    next_count = count;
    next_fire = 1'b0;
    unique case (state)
      LSM_IDLE:
      begin
        next_count = '0;
        if (level)
        begin
          next_state = LSM_WAIT;
        end
      end
      LSM_WAIT:
      begin
        if (!level)
        begin
          next_state = LSM_IDLE;
        end
        else if (count == CW'(DELAY_CYC - 1))
        begin
          next_fire = 1'b1;
          next_state = LSM_FIRED;
        end
        else
        begin
          next_count = count + 1'b1;
        end
      end
      LSM_FIRED:
      begin
        if (!level)
        begin
          next_state = LSM_IDLE;
        end
      end
      default:
      begin
        next_state = LSM_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= LSM_IDLE;
      count <= '0;
      fire <= 1'b0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      fire <= next_fire;
    end
  end

  assign busy = (state == LSM_WAIT);

endmodule : lsm_delay

// [lsm_top.sv]
// Low supply monitor: control register, synchroniser, delayed irq, wake-up
// Functional notes
// - Three-bit threshold picks one of eight trip levels, 2.0V up to 4.4V
// - Flag in bit 5 reads one while supply is below the level
// - Enable in bit 4 switches the detector on or off
// - Flag is read-only; flag, enable and threshold reset to zero
// - Control bits 7, 6 and 3 always read zero
// - Detector stays active through power-down while enabled
// - Hardware raises the interrupt request only after a fixed delay past the flag rising; a status write sets it at once
// - Drop below level in sleep sets interrupt flag and wakes device
// - Interrupt request is one source of a shared interrupt group
// - Wake-up on every rising edge of the interrupt flag while in sleep, mask ignored
`timescale 1ns/10ps
module lsm_top
  import lsm_pkg::*;
#(
  parameter int IRQ_DELAY_CYC = LSM_IRQ_DELAY_CYC,
  parameter int SETTLE_CYC = LSM_SETTLE_CYC
)
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic comparator_low,
  input wire logic sleep_mode,
  output logic monitor_enable,
  output logic [2:0] threshold_select,
  output logic settle_done,
  output logic group_irq_req,
  output logic wake_req,
  output logic irq
);

  // ==========================================================================
  // Overview
  // The control word mirrors the detector setup: enable and threshold go
  // straight out to the analog side, so a write takes effect on the edge
  // that accepts it.
  //
  // The low-supply flag is never stored. It is the synchronised comparator
  // gated by enable, so it reads zero while the detector is off and
  // follows the supply again as soon as the detector is back on.
  //
  // The interrupt flag is a separate sticky bit. Only the delay counter or
  // a status write changes it, never a read and never servicing.
  //
  // Its rising edge, and only that edge, records a wake event. A flag that
  // software presets high before sleep therefore keeps the core asleep.
  //
  // Sleep does not stop this block: the detector, the delay and the flag
  // keep running for as long as enable is set.

  // ==========================================================================
  // Register state
  lsm_ctrl_s ctrl;
  lsm_ctrl_s next_ctrl;
  logic [1:0] status;
  logic [1:0] next_status;
  logic [1:0] mask;
  logic [1:0] next_mask;
  logic low_supply_irq_flag;
  logic next_low_supply_irq_flag;
  logic irq_flag_d;
  logic [31:0] next_readdata;
  logic ack;
  logic next_ack;

  // ==========================================================================
  // Synchroniser and settle timer
  logic comp_meta;
  logic comp_sync;
  logic low_supply_flag;
  logic delay_fire;
  localparam int SW = $clog2(SETTLE_CYC + 1);
  logic [SW-1:0] settle_cnt;
  logic [SW-1:0] next_settle_cnt;

  // Two-stage synchroniser for the analog comparator
  // Nothing but comp_sync reads the first stage: the comparator moves
  // with no regard to core_clk, and a slow supply near the trip level
  // can make it chatter for many cycles.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end
    else
    begin
      comp_meta <= comparator_low;
      comp_sync <= comp_meta;
    end
  end

  // Flag is valid only while the detector is on; stays on in sleep
  assign low_supply_flag = comp_sync & ctrl.enable;

  // Settle counter restarts whenever the detector is off
  // Saturates at the settle count so settle_done stays high.
  // Software polls it before trusting the flag; the flag itself
  // is not gated on it, so early reads may still be noisy.
  always_comb
  begin
    next_settle_cnt = settle_cnt;
    if (!ctrl.enable)
    begin
      next_settle_cnt = '0;
    end
    else if (settle_cnt != SW'(SETTLE_CYC))
    begin
      next_settle_cnt = settle_cnt + 1'b1;
    end
  end

  // Settle counter register
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      settle_cnt <= '0;
    end
    else
    begin
      settle_cnt <= next_settle_cnt;
    end
  end

  assign settle_done = (settle_cnt == SW'(SETTLE_CYC));

  // Delay from flag rising to interrupt request
  // A flag that drops before expiry restarts the count, so chatter
  // near the level raises no interrupt; one request per low episode.
  // The busy output is not needed here.
  lsm_delay #(
    .DELAY_CYC(IRQ_DELAY_CYC)
  ) u_delay (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .level(low_supply_flag),
    .fire(delay_fire),
    .busy()
  );

  // ==========================================================================
  // Bus decode helpers
  function automatic logic lsm_hit(input logic [3:0] addr, input logic [3:0] ofs);
    lsm_hit = (addr == ofs);
  endfunction : lsm_hit

  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;

  // Write strobes
  // Taken only in the first cycle of a request, while ack is low, so a
  // request held through its wait state is applied exactly once.
  // Only byte lane 0 carries register bits; other lanes are ignored.
  assign wr_ctrl = avs_write & ~ack & avs_byteenable[0] & lsm_hit(avs_address, LSM_CTRL_OFS);
  assign wr_stat = avs_write & ~ack & avs_byteenable[0] & lsm_hit(avs_address, LSM_STAT_OFS);
  assign wr_mask = avs_write & ~ack & avs_byteenable[0] & lsm_hit(avs_address, LSM_MASK_OFS);

  // Next register values: writes, flag set, sticky status
  // Order inside this process matters: the status write comes first and
  // the delayed detection after it, so a hardware set in the same cycle
  // as a software clear wins. The wake bit is derived last, from the
  // final flag value, so a write that presets the flag also counts.
  always_comb
  begin
    next_ctrl = ctrl;
    next_mask = mask;
    next_low_supply_irq_flag = low_supply_irq_flag;
    next_status = status;
    if (wr_ctrl)
    begin
      next_ctrl.threshold = avs_writedata[LSM_THR_MSB:LSM_THR_LSB];
      next_ctrl.enable = avs_writedata[LSM_EN_BIT];
    end
    if (wr_mask)
    begin
      next_mask = avs_writedata[1:0];
    end
    // Status write: bit 0 is the irq flag itself, software writes it directly
    if (wr_stat)
    begin
      next_low_supply_irq_flag = avs_writedata[LSM_IRQ_BIT];
      next_status[LSM_WAKE_BIT] = status[LSM_WAKE_BIT] & ~avs_writedata[LSM_WAKE_BIT];
    end
    // Delayed detection sets the flag; set wins over clear
    if (delay_fire)
    begin
      next_low_supply_irq_flag = 1'b1;
    end
    if (next_low_supply_irq_flag & ~low_supply_irq_flag)
    begin
      next_status[LSM_WAKE_BIT] = 1'b1;
    end
    next_status[LSM_IRQ_BIT] = next_low_supply_irq_flag;
  end

  // Register file
  // Plain copy of the next values; all decisions sit in the process above.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl <= '{enable: LSM_EN_RST, threshold: LSM_THR_RST};
      mask <= LSM_MASK_RST;
      status <= LSM_STAT_RST;
      low_supply_irq_flag <= 1'b0;
      irq_flag_d <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      mask <= next_mask;
      status <= next_status;
      low_supply_irq_flag <= next_low_supply_irq_flag;
      irq_flag_d <= low_supply_irq_flag;
    end
  end

  // ==========================================================================
  // Read data and one-wait-state answer
  // Read data is registered from the address every cycle. The value the
  // master takes at the edge where waitrequest is low was captured at the
  // end of the first cycle, while the request already stood.
  // Unmapped offsets read as zero.
  always_comb
  begin
    next_readdata = 32'h0000_0000;
    next_ack = (avs_read | avs_write) & ~ack;
    if (lsm_hit(avs_address, LSM_CTRL_OFS))
    begin
      // Bits 7, 6 and 3 stay zero
      next_readdata[LSM_THR_MSB:LSM_THR_LSB] = ctrl.threshold;
      next_readdata[LSM_EN_BIT] = ctrl.enable;
      next_readdata[LSM_FLAG_BIT] = low_supply_flag;
    end
    else if (lsm_hit(avs_address, LSM_STAT_OFS))
    begin
      next_readdata[1:0] = status;
    end
    else if (lsm_hit(avs_address, LSM_MASK_OFS))
    begin
      next_readdata[1:0] = mask;
    end
  end

  // Bus answer registers
  // ack lasts one cycle: it ends the wait and blocks a second write.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      avs_readdata <= 32'h0000_0000;
      ack <= 1'b0;
    end
    else
    begin
      avs_readdata <= next_readdata;
      ack <= next_ack;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack;

  // ==========================================================================
  // Outputs to the analog side, interrupt group and wake logic
  // wake_req lasts one cycle, the one after the flag rises, and only in
  // sleep; the wake status bit keeps the event for software.
  // irq honours the mask, the wake request does not.
  assign monitor_enable = ctrl.enable;
  assign threshold_select = ctrl.threshold;
  assign group_irq_req = low_supply_irq_flag;
  assign wake_req = sleep_mode & low_supply_irq_flag & ~irq_flag_d;
  assign irq = |(status & mask);

endmodule : lsm_top

// [lsm_monitor.sv]
// Checker of the low supply monitor port behaviour
`timescale 1ns/10ps
module lsm_monitor
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic comparator_low,
  input wire logic sleep_mode,
  input wire logic monitor_enable,
  input wire logic [2:0] threshold_select,
  input wire logic group_irq_req,
  input wire logic wake_req,
  input wire logic irq
);
  // ==========================================================================
  // Port assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // Comparator seen high across synchroniser and delay
  sequence s_low_held;
    $past(comparator_low, 2) && $past(comparator_low, 3);
  endsequence
  // Flag raised by hardware, not by a write
  sequence s_hw_rise;
    $rose(group_irq_req) && !$past(avs_write);
  endsequence
  property p_delay_min;
    s_hw_rise |-> s_low_held ##0 monitor_enable;
  endproperty
  a_delay_min: assert property (p_delay_min) else $error("irq flag too early");
  property p_delay_gap;
    $rose(comparator_low) && !group_irq_req |-> !group_irq_req [*3];
  endproperty
  a_delay_gap: assert property (p_delay_gap) else $error("irq flag no delay");
  property p_wake;
    $rose(group_irq_req) && sleep_mode |-> ##[0:2] wake_req;
  endproperty
  a_wake: assert property (p_wake) else $error("wake missing");
  property p_wake_sleep;
    wake_req |-> sleep_mode;
  endproperty
  a_wake_sleep: assert property (p_wake_sleep) else $error("wake while awake");
  property p_reset;
    $rose(reset_n) |-> !monitor_enable && threshold_select == 3'h0 && !irq && !group_irq_req;
  endproperty
  a_reset: assert property (p_reset) else $error("reset value wrong");
  property p_zero;
    avs_read && !avs_waitrequest && avs_address == 4'h0 |->
      avs_readdata[31:6] == 26'h000_0000 && !avs_readdata[3];
  endproperty
  a_zero: assert property (p_zero) else $error("unused bits set");
  property p_enable;
    $changed(monitor_enable) |-> $past(avs_write) && monitor_enable == $past(avs_writedata[4]);
  endproperty
  a_enable: assert property (p_enable) else $error("enable changed alone");
  property p_thr;
    $changed(threshold_select) |->
      $past(avs_write) && threshold_select == $past(avs_writedata[2:0]);
  endproperty
  a_thr: assert property (p_thr) else $error("threshold changed alone");
endmodule : lsm_monitor

// [lsm_supply_model.sv]
// Behavioural supply comparator with eight trip levels
`timescale 1ns/10ps
module lsm_supply_model
(
  input wire logic [12:0] supply_mv,
  input wire logic monitor_enable,
  input wire logic [2:0] threshold_select,
  output logic comparator_low
);
  // ==========================================================================
  // Trip levels in millivolts, rising with the code
  int lv[8] = '{2000, 2200, 2400, 2700, 3000, 3300, 3600, 4400};
  // Low while off; sleep does not stop it
  assign comparator_low = monitor_enable && supply_mv < lv[threshold_select];
endmodule : lsm_supply_model

// [lsm_top_tb.sv]
// Testbench for the low supply monitor
`timescale 1ns/10ps
module lsm_top_tb;
  import lsm_pkg::*;
  logic core_clk = 0, reset_n = 0, avs_read = 0, avs_write = 0, sleep_mode = 0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic avs_waitrequest, comparator_low, monitor_enable, settle_done;
  logic group_irq_req, wake_req, irq;
  logic [2:0] threshold_select;
  logic [12:0] supply_mv = 13'h1388;
  int num_errors = 0, cmp_count = 0;
  int lv[8] = '{2000, 2200, 2400, 2700, 3000, 3300, 3600, 4400};
  // ==========================================================================
  // Clock and instances
  always #50 core_clk = !core_clk;
  lsm_top #(.IRQ_DELAY_CYC(2), .SETTLE_CYC(4)) lsm_top_inst (.core_clk, .reset_n,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF),
    .avs_readdata, .avs_waitrequest, .comparator_low, .sleep_mode, .monitor_enable,
    .threshold_select, .settle_done, .group_irq_req, .wake_req, .irq);
  lsm_supply_model lsm_supply_model_inst (.supply_mv, .monitor_enable, .threshold_select,
    .comparator_low);
  // Compare and count
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", s, e, g);
      num_errors++;
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  // One bus transfer, held until waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0)
    begin
      chk("bus_wait", 0, 1);
      conclude;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  // Bounded wait: 0 settle, 1 irq flag, 2 wake
  task automatic till(input int k, input int lim);
    logic s;
    s = 1'b0;
    for (int n = 0; n < lim && !s; n++)
    begin
      @(negedge core_clk);
      s = (k == 0) ? settle_done : (k == 1) ? group_irq_req : wake_req;
    end
    chk("till", 1, {31'h0, s === 1'b1});
    if (s !== 1'b1)
    begin
      conclude;
    end
  endtask : till
  task automatic t_reset;
    bus(0, LSM_CTRL_OFS, 32'h0);
    chk("ctrl_rst", 32'h0, rd);
    bus(1, LSM_CTRL_OFS, 32'hFFFF_FFFF);
    bus(0, LSM_CTRL_OFS, 32'h0);
    chk("ctrl_ro", 32'h0000_0017, rd);
    bus(0, 4'hC, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1, LSM_CTRL_OFS, 32'h0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_levels;
    for (int c = 0; c < 8; c++)
    begin
      @(posedge core_clk);
      supply_mv <= 13'(lv[c] + 10);
      bus(1, LSM_CTRL_OFS, 32'h0000_0010 | c);
      till(0, 40);
      bus(0, LSM_CTRL_OFS, 32'h0);
      chk("ctrl_hi", 32'h0000_0010 | c, rd);
      @(posedge core_clk);
      supply_mv <= 13'(lv[c] - 10);
      repeat (3) @(posedge core_clk);
      bus(0, LSM_CTRL_OFS, 32'h0);
      chk("ctrl_lo", 32'h0000_0030 | c, rd);
    end
    bus(1, LSM_CTRL_OFS, 32'h0);
    bus(0, LSM_CTRL_OFS, 32'h0);
    chk("ctrl_off", 32'h0, rd);
    bus(1, LSM_STAT_OFS, 32'h2);
    supply_mv <= 13'h1388;
    $display("level test done");
  endtask : t_levels
  task automatic t_irq;
    bus(1, LSM_CTRL_OFS, 32'h0000_0017);
    bus(1, LSM_MASK_OFS, 32'h1);
    till(0, 40);
    @(posedge core_clk);
    supply_mv <= 13'h0BB8;
    repeat (3) @(negedge core_clk);
    chk("early_irq", 0, {31'h0, group_irq_req});
    till(1, 20);
    chk("irq_on", 1, {31'h0, irq});
    bus(1, LSM_MASK_OFS, 32'h0);
    chk("irq_mask", 0, {31'h0, irq});
    bus(1, LSM_STAT_OFS, 32'h0);
    chk("irq_clr", 0, {31'h0, group_irq_req});
    bus(0, LSM_STAT_OFS, 32'h0);
    chk("stat_wake_evt", 32'h2, rd);
    bus(1, LSM_STAT_OFS, 32'h2);
    bus(0, LSM_STAT_OFS, 32'h0);
    chk("stat_w1c", 32'h0, rd);
    supply_mv <= 13'h1388;
    $display("irq test done");
  endtask : t_irq
  task automatic t_toggle;
    logic f;
    f = 1'b0;
    repeat (4)
    begin
      @(posedge core_clk);
      supply_mv <= 13'h0BB8;
      repeat (2) @(posedge core_clk);
      supply_mv <= 13'h1388;
      repeat (3)
      begin
        @(negedge core_clk);
        f = f | group_irq_req;
      end
    end
    chk("toggle_irq", 0, {31'h0, f});
    bus(0, LSM_CTRL_OFS, 32'h0);
    chk("toggle_flag", 32'h0000_0017, rd);
    $display("toggle test done");
  endtask : t_toggle
  task automatic t_sleep;
    logic w;
    w = 1'b0;
    @(posedge core_clk);
    sleep_mode <= 1'b1;
    supply_mv <= 13'h0BB8;
    till(2, 20);
    bus(0, LSM_STAT_OFS, 32'h0);
    chk("stat_wake", 32'h3, rd);
    bus(1, LSM_STAT_OFS, 32'h2);
    sleep_mode <= 1'b0;
    supply_mv <= 13'h1388;
    bus(1, LSM_STAT_OFS, 32'h1);
    @(posedge core_clk);
    sleep_mode <= 1'b1;
    supply_mv <= 13'h0BB8;
    repeat (12)
    begin
      @(negedge core_clk);
      w = w | wake_req;
    end
    chk("no_wake", 0, {31'h0, w});
    $display("sleep test done");
  endtask : t_sleep
  // Reset, then every scenario in turn
  initial
  begin
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset;
    t_levels;
    t_irq;
    t_toggle;
    t_sleep;
    conclude;
  end
endmodule : lsm_top_tb
bind lsm_top lsm_monitor lsm_monitor_inst (.core_clk, .reset_n, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .comparator_low, .sleep_mode,
  .monitor_enable, .threshold_select, .group_irq_req, .wake_req, .irq);
